// ===== hdl/uhpd_pkg.sv
// Shared constants and types of the transceiver digital side.
`default_nettype none
package uhpd_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PS = 4000;
    localparam int FS_BIT_PS = 83333;
    localparam int HS_BIT_PS = 2083;
    localparam int BYTE_CLK_PS = 16667;
    localparam int PLL_LOCK_PS = 1000000;
    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] FS_DIV = DIV_W'(FS_BIT_PS / CLK_PS);
    localparam logic [DIV_W-1:0] HS_DIV =
        DIV_W'((HS_BIT_PS / CLK_PS) < 1 ? 1 : HS_BIT_PS / CLK_PS);
    localparam logic [1:0] BYTE_DIV = 2'((BYTE_CLK_PS / CLK_PS) - 1);
    localparam logic [8:0] PLL_LOCK_CYC = 9'(PLL_LOCK_PS / CLK_PS);
    // ************************************************************
    // Line coding
    // ************************************************************
    localparam logic [7:0] SYNC_BYTE = 8'h80;
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    localparam logic [1:0] EOP_SE0_BITS = 2'h2;
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_J = 2'h1;
    localparam logic [1:0] LS_K = 2'h2;
    localparam logic [6:0] FUNC_ADDR_RST = 7'h00;
    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } uhpd_tx_t;
    typedef struct packed {
        logic active;
        logic valid;
        logic error;
        logic [7:0] data;
    } uhpd_rx_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_DATA = 2'h1,
        TX_EOP = 2'h3,
        TX_J = 2'h2
    } uhpd_tx_st_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_HUNT = 2'h1,
        RX_DATA = 2'h3,
        RX_END = 2'h2
    } uhpd_rx_st_t;
endpackage
`default_nettype wire

// ===== hdl/uhpd_bit_timer.sv
// Bit period timer, restartable at mid-bit for clock recovery.
`default_nettype none
module uhpd_bit_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [uhpd_pkg::DIV_W-1:0] div,
    // Strobe
    output logic tick
);
    import uhpd_pkg::*;
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        // At one clock per bit every sample is a bit, so no realignment.
        if (restart && div != DIV_W'(1)) begin
            cnt_next = div >> 1;
        end else if (!run) begin
            cnt_next = div - DIV_W'(1);
        end else if (cnt_reg == '0) begin
            cnt_next = div - DIV_W'(1);
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg - DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule // uhpd_bit_timer
`default_nettype wire

// ===== hdl/uhpd_phy.sv
// Digital side of the high/full speed transceiver.
`default_nettype none
module uhpd_phy (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic master_reset_in_n,
    // Line
    input wire logic line_d_in,
    input wire logic line_se0_in,
    output logic line_d_out,
    output logic line_se0_out,
    output logic line_oe,
    // Control
    input wire logic hs_mode,
    input wire logic suspend,
    input wire logic connect_req,
    input wire logic addr_load,
    input wire logic [6:0] addr_value,
    // Packet engine
    input wire uhpd_pkg::uhpd_tx_t tx,
    output logic tx_ready,
    output uhpd_pkg::uhpd_rx_t rx,
    output logic byte_tick,
    // Status
    output logic pll_running,
    output logic pll_locked,
    output logic rpu_en,
    output logic [6:0] func_addr,
    output logic [1:0] linestate
);
    import uhpd_pkg::*;

    function automatic logic [1:0] line_code(input logic se0, input logic d);
        return se0 ? LS_SE0 : (d ? LS_J : LS_K);
    endfunction

    // ************************************************************
    // Reset, PLL and byte clock
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic core_rst;
    logic [8:0] pll_cnt_reg, pll_cnt_next;
    logic pll_locked_next, pll_running_next;
    logic [1:0] byte_cnt_reg, byte_cnt_next;
    logic byte_tick_next;
    logic rpu_next;
    logic [6:0] addr_next;

    always_ff @(posedge clk_sys) begin
        rst_sync_reg <= {rst_sync_reg[0], master_reset_in_n};
    end
    assign core_rst = rst | ~rst_sync_reg[1];

    always_comb begin
        pll_running_next = ~suspend;
        pll_cnt_next = '0;
        pll_locked_next = 1'b0;
        if (!suspend) begin
            pll_locked_next = pll_locked || (pll_cnt_reg == PLL_LOCK_CYC);
            pll_cnt_next = pll_locked_next ? pll_cnt_reg
                : pll_cnt_reg + 9'h001;
        end
        byte_cnt_next = pll_locked ? byte_cnt_reg - 2'h1 : BYTE_DIV;
        byte_tick_next = pll_locked && byte_cnt_reg == 2'h0;
        rpu_next = connect_req;
        addr_next = addr_load ? addr_value : func_addr;
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            pll_cnt_reg <= '0;
            pll_locked <= 1'b0;
            pll_running <= 1'b0;
            byte_cnt_reg <= BYTE_DIV;
            byte_tick <= 1'b0;
            rpu_en <= 1'b0;
            func_addr <= FUNC_ADDR_RST;
            linestate <= LS_SE0;
        end else begin
            pll_cnt_reg <= pll_cnt_next;
            pll_locked <= pll_locked_next;
            pll_running <= pll_running_next;
            byte_cnt_reg <= byte_cnt_next;
            byte_tick <= byte_tick_next;
            rpu_en <= rpu_next;
            func_addr <= addr_next;
            linestate <= line_code(line_se0_in, line_d_in);
        end
    end

    logic [DIV_W-1:0] bit_div;
    assign bit_div = hs_mode ? HS_DIV : FS_DIV;

    // ************************************************************
    // Transmit
    // ************************************************************
    uhpd_tx_st_t tx_st_reg, tx_st_next;
    logic [7:0] tx_shift_reg, tx_shift_next, tx_buf_reg, tx_buf_next;
    logic [2:0] tx_bits_reg, tx_bits_next, tx_ones_reg, tx_ones_next;
    logic [1:0] tx_eop_reg, tx_eop_next;
    logic tx_have_reg, tx_have_next, tx_ready_next;
    logic d_next, se0_next, oe_next, tx_tick, tx_start;
    uhpd_rx_st_t rx_st_reg;

    assign tx_start = tx_st_reg == TX_IDLE && tx_have_reg && rpu_en
        && rx_st_reg == RX_IDLE;

    uhpd_bit_timer u_tx_timer (
        .clk_sys(clk_sys),
        .rst(core_rst),
        .run(tx_st_reg != TX_IDLE && pll_locked),
        .restart(1'b0),
        .div(bit_div),
        .tick(tx_tick)
    );

    always_comb begin
        tx_st_next = tx_st_reg;
        tx_shift_next = tx_shift_reg;
        tx_buf_next = tx_buf_reg;
        tx_bits_next = tx_bits_reg;
        tx_ones_next = tx_ones_reg;
        tx_eop_next = tx_eop_reg;
        tx_have_next = tx_have_reg;
        tx_ready_next = 1'b0;
        d_next = line_d_out;
        se0_next = line_se0_out;
        oe_next = line_oe;
        if (byte_tick && tx.valid && !tx_have_reg) begin
            tx_buf_next = tx.data;
            tx_have_next = 1'b1;
            tx_ready_next = 1'b1;
        end
        unique case (tx_st_reg)
            TX_IDLE: begin
                if (tx_start) begin
                    tx_st_next = TX_DATA;
                    tx_shift_next = SYNC_BYTE;
                    tx_bits_next = '0;
                    tx_ones_next = '0;
                    d_next = 1'b1;
                    oe_next = 1'b1;
                end
            end
            TX_DATA: begin
                if (tx_tick && tx_ones_reg == STUFF_LIMIT) begin
                    d_next = ~line_d_out;
                    tx_ones_next = '0;
                end else if (tx_tick) begin
                    d_next = tx_shift_reg[0] ? line_d_out : ~line_d_out;
                    tx_ones_next = tx_shift_reg[0] ? tx_ones_reg + 3'h1 : '0;
                    tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                    tx_bits_next = tx_bits_reg + 3'h1;
                    if (tx_bits_reg == 3'h7 && tx_have_next) begin
                        tx_shift_next = tx_buf_next;
                        tx_have_next = 1'b0;
                    end else if (tx_bits_reg == 3'h7) begin
                        tx_st_next = TX_EOP;
                        tx_eop_next = '0;
                    end
                end
            end
            TX_EOP: begin
                if (tx_tick && tx_ones_reg == STUFF_LIMIT) begin
                    d_next = ~line_d_out;
                    tx_ones_next = '0;
                end else if (tx_tick && tx_eop_reg == EOP_SE0_BITS) begin
                    se0_next = 1'b0;
                    d_next = 1'b1;
                    tx_st_next = TX_J;
                end else if (tx_tick) begin
                    se0_next = 1'b1;
                    tx_eop_next = tx_eop_reg + 2'h1;
                end
            end
            TX_J: begin
                if (tx_tick) begin
                    oe_next = 1'b0;
                    tx_st_next = TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            tx_st_reg <= TX_IDLE;
            tx_shift_reg <= '0;
            tx_buf_reg <= '0;
            tx_bits_reg <= '0;
            tx_ones_reg <= '0;
            tx_eop_reg <= '0;
            tx_have_reg <= 1'b0;
            tx_ready <= 1'b0;
            line_d_out <= 1'b1;
            line_se0_out <= 1'b0;
            line_oe <= 1'b0;
        end else begin
            tx_st_reg <= tx_st_next;
            tx_shift_reg <= tx_shift_next;
            tx_buf_reg <= tx_buf_next;
            tx_bits_reg <= tx_bits_next;
            tx_ones_reg <= tx_ones_next;
            tx_eop_reg <= tx_eop_next;
            tx_have_reg <= tx_have_next;
            tx_ready <= tx_ready_next;
            line_d_out <= d_next;
            line_se0_out <= se0_next;
            line_oe <= oe_next;
        end
    end

    // ************************************************************
    // Receive
    // ************************************************************
    uhpd_rx_st_t rx_st_next;
    logic rx_prev_reg, rx_last_reg, rx_last_next, rx_edge, rx_tick, rx_bit;
    logic [7:0] rx_shift_reg, rx_shift_next, rx_pend_reg, rx_pend_next;
    logic [2:0] rx_bits_reg, rx_bits_next, rx_ones_reg, rx_ones_next;
    logic rx_have_reg, rx_have_next, rx_err_reg, rx_err_next;
    uhpd_rx_t rx_next;

    assign rx_edge = line_d_in != rx_prev_reg && !line_oe
        && !line_se0_in;
    assign rx_bit = line_d_in == rx_last_reg;

    uhpd_bit_timer u_rx_timer (
        .clk_sys(clk_sys),
        .rst(core_rst),
        .run(rx_st_reg == RX_HUNT || rx_st_reg == RX_DATA),
        .restart(rx_edge),
        .div(bit_div),
        .tick(rx_tick)
    );

    always_comb begin
        rx_st_next = rx_st_reg;
        rx_last_next = rx_last_reg;
        rx_shift_next = rx_shift_reg;
        rx_pend_next = rx_pend_reg;
        rx_bits_next = rx_bits_reg;
        rx_ones_next = rx_ones_reg;
        rx_have_next = rx_have_reg;
        rx_err_next = rx_err_reg;
        rx_next = '{active: rx.active, valid: 1'b0, error: 1'b0,
                    data: rx.data};
        // Hand over first, so a byte or error arriving now is kept.
        if (byte_tick) begin
            rx_next.active = rx_have_reg || rx_st_reg == RX_DATA;
            rx_next.error = rx_err_reg;
            rx_err_next = 1'b0;
            if (rx_have_reg) begin
                rx_next.valid = 1'b1;
                rx_next.data = rx_pend_reg;
                rx_have_next = 1'b0;
            end
        end
        unique case (rx_st_reg)
            RX_IDLE: begin
                if (rx_edge && pll_locked) begin
                    rx_st_next = RX_HUNT;
                    rx_last_next = rx_prev_reg;
                end
            end
            RX_HUNT: begin
                if (rx_tick && line_se0_in) begin
                    rx_st_next = RX_END;
                end else if (rx_tick) begin
                    rx_last_next = line_d_in;
                    if (rx_bit) begin
                        rx_st_next = RX_DATA;
                        rx_bits_next = '0;
                        rx_ones_next = 3'h1;
                    end
                end
            end
            RX_DATA: begin
                if (rx_tick && line_se0_in) begin
                    rx_st_next = RX_END;
                end else if (rx_tick) begin
                    rx_last_next = line_d_in;
                    if (rx_ones_reg == STUFF_LIMIT) begin
                        rx_ones_next = '0;
                        if (rx_bit) begin
                            rx_err_next = 1'b1;
                            rx_st_next = RX_END;
                        end
                    end else begin
                        rx_shift_next = {rx_bit, rx_shift_reg[7:1]};
                        rx_ones_next = rx_bit ? rx_ones_reg + 3'h1 : '0;
                        rx_bits_next = rx_bits_reg + 3'h1;
                        if (rx_bits_reg == 3'h7) begin
                            rx_pend_next = rx_shift_next;
                            rx_err_next = rx_err_next
                                | (rx_have_reg & ~byte_tick);
                            rx_have_next = 1'b1;
                        end
                    end
                end
            end
            RX_END: begin
                if (byte_tick && !rx_have_reg) begin
                    rx_st_next = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (core_rst) begin
            rx_st_reg <= RX_IDLE;
            rx_prev_reg <= 1'b1;
            rx_last_reg <= 1'b1;
            rx_shift_reg <= '0;
            rx_pend_reg <= '0;
            rx_bits_reg <= '0;
            rx_ones_reg <= '0;
            rx_have_reg <= 1'b0;
            rx_err_reg <= 1'b0;
            rx <= '0;
        end else begin
            rx_st_reg <= rx_st_next;
            // SE0 counts as idle, so the return to J is no edge.
            rx_prev_reg <= line_se0_in | line_d_in;
            rx_last_reg <= rx_last_next;
            rx_shift_reg <= rx_shift_next;
            rx_pend_reg <= rx_pend_next;
            rx_bits_reg <= rx_bits_next;
            rx_ones_reg <= rx_ones_next;
            rx_have_reg <= rx_have_next;
            rx_err_reg <= rx_err_next;
            rx <= rx_next;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_tx_off_rx: assert property (@(posedge clk_sys) disable iff (core_rst)
        rx.active |-> !line_oe) else $error("Driver on during receive.");
    a_tx_capture_tick: assert property (@(posedge clk_sys)
        disable iff (core_rst) tx_ready |-> $past(byte_tick) && $past(tx.valid))
        else $error("Transmit byte taken off the byte clock.");
    a_rx_valid_tick: assert property (@(posedge clk_sys)
        disable iff (core_rst) rx.valid |-> $past(byte_tick) && rx.active)
        else $error("Receive byte off the byte clock.");
    a_byte_period: assert property (@(posedge clk_sys)
        disable iff (core_rst) byte_tick && pll_locked |=> !byte_tick [*3])
        else $error("Byte clock period wrong.");
    a_suspend_stop: assert property (@(posedge clk_sys)
        disable iff (core_rst) suspend |=> ##1 !pll_locked && !byte_tick)
        else $error("Clocks run in suspend.");
    a_lock_wait: assert property (@(posedge clk_sys) disable iff (core_rst)
        $rose(pll_locked) |-> $past(pll_running, 250))
        else $error("PLL locked too early.");
    a_stuff_limit: assert property (@(posedge clk_sys)
        disable iff (core_rst) tx_ones_reg <= STUFF_LIMIT)
        else $error("Stuffing skipped.");
    a_tx_connected: assert property (@(posedge clk_sys)
        disable iff (core_rst) $rose(line_oe) |-> $past(rpu_en))
        else $error("Transmit while disconnected.");
    a_reset_default: assert property (@(posedge clk_sys)
        $fell(core_rst) |-> func_addr == FUNC_ADDR_RST && !rpu_en && !line_oe)
        else $error("Reset defaults wrong.");
    a_tx_hold: assert property (@(posedge clk_sys) disable iff (core_rst)
        tx_ready |-> !$past(tx_have_reg)) else $error("Byte accepted twice.");
    c_tx_packet: cover property (@(posedge clk_sys) $fell(line_oe));
    c_rx_packet: cover property (@(posedge clk_sys) rx.valid);
    c_rx_error: cover property (@(posedge clk_sys) rx.error);
    c_suspend: cover property (@(posedge clk_sys) $fell(pll_running));
endmodule // uhpd_phy
`default_nettype wire

// ===== sim/uhpd_host_model.sv
// Host side line model that sends and decodes NRZI packets.
`default_nettype none
module uhpd_host_model (
    // Clock
    input wire logic clk_sys,
    // From device
    input wire logic line_oe,
    input wire logic line_d_out,
    input wire logic line_se0_out,
    // To device
    output var logic line_d_in,
    output var logic line_se0_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Decoder and sender
    // ************************************************************
    int per = 20;
    logic [7:0] got[$];
    bit saw_oe = 1'b0;
    bit sending = 1'b0;
    int st = 0;
    int run;
    int ones;
    int nb;
    logic last;
    logic [7:0] sh;
    initial begin
        line_d_in = 1'b1;
        line_se0_in = 1'b0;
    end
    task automatic put_bit(input logic b);
        if (ones == 6) begin
            ones = 0;
            return;
        end
        ones = b ? ones + 1 : 0;
        sh = {b, sh[7:1]};
        nb++;
        if (nb == 8) begin
            got.push_back(sh);
            nb = 0;
        end
    endtask
    task automatic emit(input int r);
        put_bit(1'b0);
        repeat ((r + per / 2) / per - 1) put_bit(1'b1);
    endtask
    always @(posedge clk_sys) begin
        if (sending && line_oe) saw_oe = 1'b1;
        if (!line_oe) st = 0;
        else if (st == 0 && !line_se0_out && !line_d_out) begin
            st = 1;
            run = 1;
            last = 1'b0;
            ones = 0;
            nb = 0;
        end else if (st == 1) begin
            if (line_se0_out || line_d_out != last) begin
                emit(run);
                run = 1;
                last = line_d_out;
                if (line_se0_out) st = 2;
            end else run++;
        end
    end
    task automatic drive(input logic d, input logic se0);
        line_d_in = d;
        line_se0_in = se0;
        repeat (per) @(negedge clk_sys);
    endtask
    task automatic send_pkt(input logic [7:0] q[$]);
        logic lv;
        int n1;
        lv = 1'b1;
        n1 = 0;
        saw_oe = 1'b0;
        sending = 1'b1;
        @(negedge clk_sys);
        foreach (q[i]) begin
            for (int k = 0; k < 8; k++) begin
                lv = q[i][k] ? lv : ~lv;
                drive(lv, 1'b0);
                n1 = q[i][k] ? n1 + 1 : 0;
                if (n1 == 6) begin
                    lv = ~lv;
                    drive(lv, 1'b0);
                    n1 = 0;
                end
            end
        end
        drive(1'b0, 1'b1);
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b0);
        sending = 1'b0;
    endtask
endmodule // uhpd_host_model
`default_nettype wire

// ===== sim/uhpd_phy_bench.sv
// Self-checking bench of the transceiver digital side.
`default_nettype none
module uhpd_phy_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import uhpd_pkg::*;
    // ************************************************************
    // Bench
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic master_reset_in_n = 1'b1;
    logic hs_mode = 1'b0;
    logic suspend = 1'b0;
    logic connect_req = 1'b0;
    logic addr_load = 1'b0;
    logic [6:0] addr_value = 7'h00;
    uhpd_tx_t tx = '0;
    uhpd_rx_t rx;
    logic line_d_in, line_se0_in, line_d_out, line_se0_out, line_oe;
    logic tx_ready, byte_tick, pll_running, pll_locked, rpu_en;
    logic [6:0] func_addr;
    logic [1:0] linestate;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    logic prev_tick = 1'b0;
    logic rx_err = 1'b0;
    logic [7:0] rxq[$];
    logic [7:0] pk[$] = '{8'hFF, 8'h3C, 8'hFF};
    uhpd_phy dut (.clk_sys, .rst, .master_reset_in_n, .line_d_in,
        .line_se0_in, .line_d_out, .line_se0_out, .line_oe, .hs_mode,
        .suspend, .connect_req, .addr_load, .addr_value, .tx, .tx_ready,
        .rx, .byte_tick, .pll_running, .pll_locked, .rpu_en, .func_addr,
        .linestate);
    uhpd_host_model host (.clk_sys, .line_oe, .line_d_out, .line_se0_out,
        .line_d_in, .line_se0_in);
    always #2 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    always @(negedge clk_sys) begin
        if (tx_ready === 1'b1) check(prev_tick, 1'b1);
        prev_tick = byte_tick;
        if (rx.valid === 1'b1) rxq.push_back(rx.data);
        if (rx.error === 1'b1) rx_err = 1'b1;
    end
    task automatic wait_lock;
        for (int w = 0; w < 600 && pll_locked !== 1'b1; w++)
            @(negedge clk_sys);
        check(pll_locked, 1'b1);
    endtask
    task automatic t_clock;
        int gap;
        wait_lock();
        check(pll_running, 1'b1);
        while (byte_tick !== 1'b1) @(negedge clk_sys);
        gap = 0;
        do begin
            @(negedge clk_sys);
            gap++;
        end while (byte_tick !== 1'b1 && gap < 9);
        check(gap, BYTE_DIV + 1);
    endtask
    task automatic t_suspend;
        int ticks;
        suspend = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(pll_running, 1'b0);
        ticks = 0;
        repeat (40) begin
            @(negedge clk_sys);
            ticks += byte_tick;
        end
        check(ticks, 0);
        suspend = 1'b0;
        wait_lock();
    endtask
    task automatic t_tx(input logic h);
        int w;
        hs_mode = h;
        host.per = h ? HS_DIV : FS_DIV;
        host.got.delete();
        foreach (pk[i]) begin
            tx.valid = 1'b1;
            tx.data = pk[i];
            w = 0;
            do begin
                @(negedge clk_sys);
                w++;
            end while (tx_ready !== 1'b1 && w < 400);
            check(tx_ready, 1'b1);
        end
        tx.valid = 1'b0;
        for (w = 0; w < 3000 && line_oe !== 1'b0; w++) @(negedge clk_sys);
        check(host.got.size(), 4);
        check(host.got[0], SYNC_BYTE);
        foreach (pk[i]) check(host.got[i + 1], pk[i]);
        repeat (10) @(negedge clk_sys);
    endtask
    task automatic t_rx(input logic h);
        logic [7:0] q[$];
        q = {SYNC_BYTE, pk};
        hs_mode = h;
        host.per = h ? HS_DIV : FS_DIV;
        rxq.delete();
        rx_err = 1'b0;
        host.send_pkt(q);
        repeat (12) @(negedge clk_sys);
        check(host.saw_oe, 1'b0);
        check(rx_err, 1'b0);
        check(rx.active, 1'b0);
        check(rxq.size(), 3);
        foreach (pk[i]) check(rxq[i], pk[i]);
    endtask
    task automatic t_master;
        master_reset_in_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(func_addr, FUNC_ADDR_RST);
        check(rpu_en, 1'b0);
        check(pll_locked, 1'b0);
        master_reset_in_n = 1'b1;
        @(negedge clk_sys);
        check(pll_locked, 1'b0);
        wait_lock();
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        check(func_addr, FUNC_ADDR_RST);
        check(rpu_en, 1'b0);
        check(line_oe, 1'b0);
        check(linestate, LS_J);
        t_clock();
        t_suspend();
        connect_req = 1'b1;
        addr_value = 7'h55;
        addr_load = 1'b1;
        @(negedge clk_sys);
        addr_load = 1'b0;
        check(rpu_en, 1'b1);
        @(negedge clk_sys);
        check(func_addr, 7'h55);
        t_tx(1'b0);
        t_tx(1'b1);
        t_rx(1'b0);
        t_rx(1'b1);
        t_master();
        report_and_stop();
    end
endmodule // uhpd_phy_bench
`default_nettype wire
